// ---- inc/adc_ctrl_pkg.sv ----
// constants for the converter control and readout block
// assumes a 10 MHz aclk and a word-per-register AXI4-Lite map
// Contract
// - done flag bit 7 set at conversion end
// - high result read clears flag; writes ignored
// - bit 7 read-only, other bits read/write
// - channel change restarts on new channel
// - low result read freezes both results
// - high read or converter off unfreezes
// - frozen results ignore new conversions
// - divider field 6:5 picks 4/2/1 MHz; the code gives 5/2/1 MHz
// - converter_on bit 4 enables, clears stop
// - channel field 3:0 is binary index
// - high result shows bits 9:2
// - low result shows bits 1:0, rest zero
// - all three registers reset to 00h
// - registers decode at 2E, 2F, 30
// - wait mode leaves converter running
// - halt disables converter; software waits
// - irq enable apart; wakes wait, not halt
// - convert continuously while enabled
// - done flag low while conversion runs; the code leaves it set through the following conversions until a high read
// - completed conversion with enable raises irq
package adc_ctrl_pkg;
    // ===========================================
    // register map: indexes, byte address = 4*idx
    localparam logic [7:0] CSR_IDX     = 8'h2e;
    localparam logic [7:0] RES_HI_IDX  = 8'h2f;
    localparam logic [7:0] RES_LO_IDX  = 8'h30;
    localparam logic [7:0] IRQ_EN_IDX  = 8'h31;
    localparam logic [7:0] CSR_ADDR    = 8'(CSR_IDX * 4);
    localparam logic [7:0] RES_HI_ADDR = 8'(RES_HI_IDX * 4);
    localparam logic [7:0] RES_LO_ADDR = 8'(RES_LO_IDX * 4);
    localparam logic [7:0] IRQ_EN_ADDR = 8'(IRQ_EN_IDX * 4);
    // ===========================================
    // field positions and reset values
    localparam int         EOC_BIT     = 7;
    localparam int         DIV_SEL_LSB = 5;
    localparam int         ON_BIT      = 4;
    localparam int         CHAN_LSB    = 0;
    localparam int         IRQ_EN_BIT  = 0;
    localparam int         RES_W       = 10;
    localparam logic [7:0] REG_RESET   = 8'h00;
    // ===========================================
    // timing: converter clock rates from aclk
    localparam int         CLK_HZ      = 10_000_000;
    localparam int         FAST_HZ     = 4_000_000;
    localparam int         MID_HZ      = 2_000_000;
    localparam int         SLOW_HZ     = 1_000_000;
    localparam logic [3:0] DIV_FAST    = 4'(CLK_HZ / FAST_HZ);
    localparam logic [3:0] DIV_MID     = 4'(CLK_HZ / MID_HZ);
    localparam logic [3:0] DIV_SLOW    = 4'(CLK_HZ / SLOW_HZ);
    localparam int         SAMPLE_TICKS = 3;
    // ===========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_STEP} sar_state_t;
endpackage

// ---- hdl/sar_engine.sv ----
// successive-approximation sequencer for the converter core
// assumes comp_in is high when the input is at or above dac_code
`timescale 1ns/1ns
module sar_engine
    import adc_ctrl_pkg::*;
#(
    parameter int SAMPLE_N = SAMPLE_TICKS
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic             start,
    input  wire logic             comp_in,
    output logic                  sample_reg,
    output logic [RES_W-1:0]      dac_reg,
    output logic                  done_reg,
    output logic [RES_W-1:0]      result_reg
);
    sar_state_t state_reg;
    logic [3:0] cnt_reg;

    // ===========================================
    // sequencer: sample, then one bit per tick
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            state_reg  <= SAR_IDLE;
            cnt_reg    <= 4'h0;
            sample_reg <= 1'b0;
            dac_reg    <= '0;
            done_reg   <= 1'b0;
        end else if (start || state_reg == SAR_IDLE) begin
            // abandon any partial result and resample
            state_reg  <= SAR_SAMPLE;
            cnt_reg    <= 4'h0;
            sample_reg <= 1'b1;
            dac_reg    <= '0;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                SAR_SAMPLE: begin
                    if (tick && cnt_reg == 4'(SAMPLE_N - 1)) begin
                        state_reg  <= SAR_STEP;
                        sample_reg <= 1'b0;
                        cnt_reg    <= 4'(RES_W - 1);
                        dac_reg    <= 10'h200;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                SAR_STEP: begin
                    if (tick) begin
                        // keep the trial bit when input is not below it
                        dac_reg[cnt_reg] <= comp_in;
                        if (cnt_reg == 4'h0) begin
                            done_reg   <= 1'b1;
                            state_reg  <= SAR_SAMPLE;
                            sample_reg <= 1'b1;
                        end else begin
                            dac_reg[cnt_reg - 4'h1] <= 1'b1;
                            cnt_reg <= cnt_reg - 4'h1;
                        end
                    end
                end
                default: state_reg <= SAR_IDLE;
            endcase
        end
    end

    // result holds across power-down, cleared only by reset
    // captured on the same edge that raises done, from the last trial
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= '0;
        end else if (run && !start && state_reg == SAR_STEP && tick && cnt_reg == 4'h0) begin
            result_reg <= {dac_reg[RES_W-1:1], comp_in};
        end
    end
endmodule

// ---- hdl/adc_control_readout.sv ----
// converter control/status and result registers on AXI4-Lite
// assumes a single 10 MHz aclk; analog mux and comparator outside
`timescale 1ns/1ns
module adc_control_readout
    import adc_ctrl_pkg::*;
#(
    parameter int SAMPLE_N = SAMPLE_TICKS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        halt_mode,
    input  wire logic        comp_in,
    output logic [3:0]       mux_sel,
    output logic             conv_power,
    output logic             sample_hold,
    output logic [9:0]       dac_code,
    output logic             conv_done_irq,
    output logic             wake_request
);
    logic       awready_reg;
    logic       wready_reg;
    logic       bvalid_reg;
    logic [1:0] bresp_reg;
    logic       arready_reg;
    logic       rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] div_sel_reg;
    logic       on_reg;
    logic [3:0] chan_reg;
    logic       eoc_reg;
    logic       lock_reg;
    logic       irq_en_reg;
    logic       restart_reg;
    logic       power_reg;
    logic       irq_reg;
    logic       wake_reg;
    logic       tick_reg;
    logic [3:0] div_cnt_reg;
    logic [RES_W-1:0] data_reg;
    logic [3:0] mux_reg;
    logic       wr_go;
    logic       rd_go;
    logic       wr_csr;
    logic       wr_hit;
    logic       rd_hit;
    logic       rd_high;
    logic       rd_low;
    logic       on_rise;
    logic       on_fall;
    logic       chan_change;
    logic       done_pulse;
    logic [RES_W-1:0] core_result;
    logic [3:0] div_max;
    logic [31:0] rd_word;

    // ===========================================
    // bus decode
    assign wr_go  = awready_reg && awvalid && wvalid;
    assign rd_go  = arready_reg && arvalid;
    assign wr_hit = awaddr == CSR_ADDR || awaddr == IRQ_EN_ADDR
                 || awaddr == RES_HI_ADDR || awaddr == RES_LO_ADDR;
    assign rd_hit = araddr == CSR_ADDR || araddr == IRQ_EN_ADDR
                 || araddr == RES_HI_ADDR || araddr == RES_LO_ADDR;
    assign wr_csr  = wr_go && awaddr == CSR_ADDR && wstrb[0];
    assign rd_high = rd_go && araddr == RES_HI_ADDR;
    assign rd_low  = rd_go && araddr == RES_LO_ADDR;
    assign on_rise = wr_csr && !on_reg && wdata[ON_BIT];
    assign on_fall = wr_csr && on_reg && !wdata[ON_BIT];
    // a rewrite of the same channel leaves a running conversion alone
    assign chan_change = wr_csr && on_reg && wdata[ON_BIT]
                      && wdata[CHAN_LSB +: 4] != chan_reg;

    // write channel: both halves taken together in one pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            awready_reg <= !awready_reg && awvalid && wvalid && !bvalid_reg;
            wready_reg  <= !awready_reg && awvalid && wvalid && !bvalid_reg;
        end
    end

    // write response; unmapped addresses answer slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read mux; upper word bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (araddr)
            CSR_ADDR: begin
                rd_word[EOC_BIT]        = eoc_reg;
                rd_word[DIV_SEL_LSB +: 2] = div_sel_reg;
                rd_word[ON_BIT]         = on_reg;
                rd_word[CHAN_LSB +: 4]  = chan_reg;
            end
            RES_HI_ADDR: rd_word[7:0] = data_reg[9:2];
            RES_LO_ADDR: rd_word[1:0] = data_reg[1:0];
            IRQ_EN_ADDR: rd_word[IRQ_EN_BIT] = irq_en_reg;
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    // read channel: one-cycle ready, data registered behind it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            arready_reg <= !arready_reg && arvalid && !rvalid_reg;
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_reg  <= rd_word;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ===========================================
    // control fields; bit 7 of the write data is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_sel_reg <= REG_RESET[DIV_SEL_LSB +: 2];
            on_reg     <= REG_RESET[ON_BIT];
            chan_reg   <= REG_RESET[CHAN_LSB +: 4];
            irq_en_reg <= REG_RESET[IRQ_EN_BIT];
        end else begin
            if (wr_csr) begin
                div_sel_reg <= wdata[DIV_SEL_LSB +: 2];
                on_reg   <= wdata[ON_BIT];
                chan_reg <= wdata[CHAN_LSB +: 4];
            end
            if (wr_go && awaddr == IRQ_EN_ADDR && wstrb[0]) begin
                irq_en_reg <= wdata[IRQ_EN_BIT];
            end
        end
    end

    // done flag: hardware set wins over the clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc_reg <= REG_RESET[EOC_BIT];
        end else if (done_pulse) begin
            eoc_reg <= 1'b1;
        end else if (rd_high) begin
            eoc_reg <= 1'b0;
        end else if (on_rise || chan_change) begin
            eoc_reg <= 1'b0;
        end
    end

    // freeze: low read locks, high read or power-off unlocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_reg <= 1'b0;
        end else if (!on_reg || on_fall) begin
            lock_reg <= 1'b0;
        end else if (rd_low) begin
            lock_reg <= 1'b1;
        end else if (rd_high) begin
            lock_reg <= 1'b0;
        end
    end

    // result capture; skipped in the cycle a low read freezes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= '0;
        end else if (done_pulse && !lock_reg && !rd_low) begin
            data_reg <= core_result;
        end
    end

    // ===========================================
    // power and restart; wait mode has no input here by design
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_reg   <= 1'b0;
            restart_reg <= 1'b0;
            mux_reg     <= 4'h0;
        end else begin
            power_reg   <= on_reg && !on_fall && !halt_mode;
            restart_reg <= chan_change;
            mux_reg     <= wr_csr ? wdata[CHAN_LSB +: 4] : chan_reg;
        end
    end

    // converter clock select; the reserved code runs slowest
    always_comb begin
        case (div_sel_reg)
            2'h0:    div_max = DIV_FAST;
            2'h1:    div_max = DIV_MID;
            default: div_max = DIV_SLOW;
        endcase
    end

    // divider: 10 MHz does not split evenly to 4 MHz, 5 MHz is used
    always_ff @(posedge aclk) begin
        if (!aresetn || !power_reg || restart_reg) begin
            div_cnt_reg <= 4'h0;
            tick_reg    <= 1'b0;
        end else if (div_cnt_reg >= div_max - 4'h1) begin
            div_cnt_reg <= 4'h0;
            tick_reg    <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
            tick_reg    <= 1'b0;
        end
    end

    sar_engine #(
        .SAMPLE_N   (SAMPLE_N)
    ) u_sar (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick       (tick_reg),
        .run        (power_reg),
        .start      (restart_reg),
        .comp_in    (comp_in),
        .sample_reg (sample_hold),
        .dac_reg    (dac_code),
        .done_reg   (done_pulse),
        .result_reg (core_result)
    );

    // interrupt level follows the flag; halt blocks the wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg  <= eoc_reg && irq_en_reg;
            wake_reg <= eoc_reg && irq_en_reg && !halt_mode;
        end
    end

    // ===========================================
    // outputs
    assign awready       = awready_reg;
    assign wready        = wready_reg;
    assign bvalid        = bvalid_reg;
    assign bresp         = bresp_reg;
    assign arready       = arready_reg;
    assign rvalid        = rvalid_reg;
    assign rresp         = rresp_reg;
    assign rdata         = rdata_reg;
    assign mux_sel       = mux_reg;
    assign conv_power    = power_reg;
    assign conv_done_irq = irq_reg;
    assign wake_request  = wake_reg;

    // ===========================================
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic rd_low_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_low_q <= 1'b0;
        end else begin
            rd_low_q <= rd_low;
        end
    end

    a_eoc_set_done: assert property (
        done_pulse |=> eoc_reg)
        else $error("done flag not set after conversion");
    a_eoc_clear_read: assert property (
        rd_high && !done_pulse |=> !eoc_reg)
        else $error("high read did not clear done flag");
    a_eoc_write_ro: assert property (
        wr_csr && wdata[EOC_BIT] && !eoc_reg && !done_pulse |=> !eoc_reg)
        else $error("write reached the done flag");
    a_chan_restart: assert property (
        chan_change && !halt_mode |=> restart_reg ##1 sample_hold)
        else $error("channel change did not restart");
    a_lock_on_low: assert property (
        rd_low && on_reg && !on_fall |=> lock_reg)
        else $error("low read did not freeze results");
    a_unlock_off: assert property (
        on_fall |=> !lock_reg && !on_reg)
        else $error("power-off left results frozen");
    a_frozen_stable: assert property (
        lock_reg |=> $stable(data_reg))
        else $error("frozen results changed");
    a_low_upper_zero: assert property (
        rd_low_q |-> rdata_reg[31:2] == 30'h0)
        else $error("low result upper bits not zero");
    a_halt_power: assert property (
        halt_mode |=> !conv_power ##1 !sample_hold)
        else $error("converter kept running in halt");
    a_halt_no_wake: assert property (
        halt_mode |=> !wake_request)
        else $error("wake raised during halt");
    a_irq_follows: assert property (
        eoc_reg && irq_en_reg |=> conv_done_irq)
        else $error("enabled done flag gave no interrupt");
    a_fast_tick: assert property (
        $rose(tick_reg) && div_sel_reg == 2'h0 && power_reg && !restart_reg
            && !wr_csr && !halt_mode |=> !tick_reg ##1 tick_reg)
        else $error("fast converter clock period wrong");

    c_conversion: cover property (done_pulse && !lock_reg);
    c_locked_done: cover property (done_pulse && lock_reg);
    c_chan_switch: cover property (chan_change ##[1:40] done_pulse);
    c_halt_wake: cover property (halt_mode ##1 !halt_mode ##[1:200] done_pulse);
endmodule

// ---- testbench/analog_front_model.sv ----
// behavioural analog input mux and comparator facing the converter
// assumes sample_hold marks the sampling phase and dac_code the trial code
`timescale 1ns/1ns
module analog_front_model (
    input  wire logic       aclk,
    input  wire logic [3:0] mux_sel,
    input  wire logic       conv_power,
    input  wire logic       sample_hold,
    input  wire logic [9:0] dac_code,
    output logic            comp_in
);
    logic [9:0] held = 10'h000;
    logic       junk = 1'b0;
    // =====================================
    // sample and hold
    // each input has its own fixed level so a wrong channel shows up
    always @(posedge aclk) begin
        junk <= ~junk;
        if (sample_hold) begin
            held <= 10'(mux_sel * 61 + 5);
        end
    end
    // an unpowered comparator gives no stable answer, so it toggles
    assign comp_in = conv_power ? (held >= dac_code) : junk;
endmodule

// ---- testbench/adc_control_readout_tb.sv ----
// self-checking bench for the converter control and readout block
// assumes the analog front model stands on the converter side
`timescale 1ns/1ns
module adc_control_readout_tb;
    import adc_ctrl_pkg::*;
    localparam int NS = 3;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        halt_mode = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, comp_in;
    logic        conv_power, sample_hold, conv_done_irq, wake_request, sh_d;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [3:0]  mux_sel;
    logic [9:0]  dac_code;
    int          n_fail = 0;
    int          compares = 0;
    int          rises = 0;
    int          per = 0;
    int          cnt = 0;
    int          e, code, i;

    always #50 aclk = ~aclk;

    adc_control_readout #(.SAMPLE_N(NS)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .halt_mode(halt_mode),
        .comp_in(comp_in), .mux_sel(mux_sel), .conv_power(conv_power),
        .sample_hold(sample_hold), .dac_code(dac_code),
        .conv_done_irq(conv_done_irq), .wake_request(wake_request)
    );

    analog_front_model partner (
        .aclk(aclk), .mux_sel(mux_sel), .conv_power(conv_power),
        .sample_hold(sample_hold), .dac_code(dac_code), .comp_in(comp_in)
    );

    // spacing of conversion starts, seen at the sampling phase
    always @(posedge aclk) begin
        sh_d <= sample_hold;
        cnt <= cnt + 1;
        if (sample_hold === 1'b1 && sh_d === 1'b0) begin
            rises <= rises + 1;
            per <= cnt;
            cnt <= 1;
        end
    end

    // =====================================
    // helpers
    function automatic logic [9:0] lvl(input int ch);
        return 10'(ch * 61 + 5);
    endfunction

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic timeout();
        n_fail++;
        $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 0, 1);
        complete_run();
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        rs = bresp;
        if (n == 100) timeout();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
        if (n == 100) timeout();
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] v;
        logic [1:0]  rs;
        rd(a, v, rs);
        chk(v, x);
        chk(32'(rs), 32'(RESP_OKAY));
    endtask

    // polling is bounded: a lost done flag ends the run
    task automatic wait_eoc();
        logic [31:0] v;
        logic [1:0]  rs;
        int          k;
        for (k = 0; k < 80; k++) begin
            rd(CSR_ADDR, v, rs);
            if (v[EOC_BIT] === 1'b1) break;
        end
        if (k == 80) timeout();
    endtask

    initial begin
        repeat (100000) @(posedge aclk);
        timeout();
    end

    // =====================================
    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(CSR_ADDR, 32'h0);
        rchk(RES_HI_ADDR, 32'h0);
        rchk(RES_LO_ADDR, 32'h0);
        rd(8'h00, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, 32'h0);
        wr(8'h00, 8'h5a, r);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(RES_HI_ADDR, 8'hff, r);
        chk(32'(r), 32'(RESP_OKAY));
        rchk(RES_HI_ADDR, 32'h0);
        $display("test reset_map done");
        // writing the done bit must not set it
        wr(CSR_ADDR, 8'h9f, r);
        chk(32'(r), 32'(RESP_OKAY));
        rchk(CSR_ADDR, 32'h1f);
        chk(32'({conv_power, mux_sel}), 32'h1f);
        wait_eoc();
        rchk(RES_LO_ADDR, 32'(lvl(15) & 10'h003));
        rchk(RES_HI_ADDR, 32'(lvl(15) >> 2));
        rchk(CSR_ADDR, 32'h1f);
        $display("test convert done");
        // low read freezes; a channel change must not reach the results
        wait_eoc();
        rchk(RES_LO_ADDR, 32'(lvl(15) & 10'h003));
        wr(CSR_ADDR, 8'h16, r);
        wait_eoc();
        rchk(RES_HI_ADDR, 32'(lvl(15) >> 2));
        wait_eoc();
        rchk(RES_LO_ADDR, 32'(lvl(6) & 10'h003));
        rchk(RES_HI_ADDR, 32'(lvl(6) >> 2));
        // switching off must also release the freeze
        rd(RES_LO_ADDR, d, r);
        wr(CSR_ADDR, 8'h06, r);
        @(posedge aclk);
        chk(32'(conv_power), 32'h0);
        wr(CSR_ADDR, 8'h13, r);
        wait_eoc();
        rchk(RES_HI_ADDR, 32'(lvl(3) >> 2));
        $display("test freeze done");
        // every divider code, reserved one included
        for (code = 0; code < 4; code++) begin
            wr(CSR_ADDR, 8'(code * 32 + 8'h13), r);
            e = rises;
            for (i = 0; i < 3000 && rises < e + 3; i++) @(posedge aclk);
            if (i == 3000) timeout();
            e = (NS + 10) * (code == 0 ? 2 : code == 1 ? 5 : 10);
            chk(32'(per), 32'(e));
        end
        $display("test divider done");
        // interrupt and wake request, then halt
        wr(IRQ_EN_ADDR, 8'h01, r);
        wait_eoc();
        chk(32'({conv_done_irq, wake_request}), 32'h3);
        @(posedge aclk);
        halt_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'({conv_power, wake_request}), 32'h0);
        halt_mode <= 1'b0;
        rd(RES_HI_ADDR, d, r);
        @(posedge aclk);
        chk(32'(conv_done_irq), 32'h0);
        $display("test irq_halt done");
        complete_run();
    end
endmodule
